// ---- rtl/tcore_out_req.sv ----
// Channel output gating, polarity and event request enables of the timer
//
// How it works
// [R1] Enable register at 0x074 holds all DMA and IRQ enables, reset zero
// [R2] Bit 26 lets trigger events raise a DMA request
// [R3] Bit 24 lets update events raise a DMA request
// [R4] Bits 19..16 let compare events of channels 3..0 raise DMA requests
// [R5] Bit 10 lets the trigger flag raise an interrupt
// [R6] Bit 8 lets the update flag raise an interrupt
// [R7] Bits 3..0 let compare flags of channels 3..0 raise interrupts
// [R8] Polarity at 0x054, bits 6,4,2,0; one means active low
// [R9] Channel output reaches its pin only while its enable bit is one
// [R10] Interrupt line is high while flag set and enable bit one
// [R11] Overflow, software generate or slave restart: update, sets flag
// [R12] Trigger flag set by hardware, held until software writes zero
// [R13] Compare flag set on match except in center-aligned counting
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tcore_defs.svh"
module tcore_out_req #(
    parameter int NCH = 4                       // Channel count
) (
    input  wire logic               clock,      // Peripheral clock
    input  wire logic               sys_rst,    // Synchronous reset
    input  wire logic               psel,       // APB select
    input  wire logic               penable,    // APB access phase
    input  wire logic               pwrite,     // APB write
    input  wire logic [11:0]        paddr,      // APB byte address
    input  wire logic [31:0]        pwdata,     // APB write data
    output logic      [31:0]        prdata,     // APB read data
    output logic                    pready,     // APB ready
    output logic                    pslverr,    // APB error
    input  wire logic [NCH-1:0]     chan_ref,   // Reference level per channel
    input  wire tcore_pkg::tcore_evt_t evt,     // Event strobes
    input  wire logic               center_mode, // Center-aligned counting
    input  wire logic               sw_update_generate, // Software update
    output logic      [NCH-1:0]     chan_pin_out, // Channel pin levels
    output tcore_pkg::tcore_req_t   irq_req,    // Interrupt request levels
    output tcore_pkg::tcore_req_t   dma_req     // DMA request pulses
);
    import tcore_pkg::*;

    logic [31:0] channel_output_enable;
    logic [31:0] output_polarity_config;
    logic [31:0] dma_and_interrupt_enable;
    logic [31:0] event_flags;
    logic        acc;
    logic        wr;
    logic        upd_evt;
    logic [NCH-1:0] match_evt;
    logic [31:0] flag_set;
    logic [31:0] next_flags;
    logic        mapped;
    wire logic [NCH-1:0] next_pin_out;

    // Address decode used only for the error response
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `TCORE_OFS_OUT_EN) || (a == `TCORE_OFS_POLARITY) ||
                    (a == `TCORE_OFS_REQ_EN) || (a == `TCORE_OFS_FLAGS);
    endfunction : is_mapped

    // APB handshake, zero wait states
    assign acc     = psel && penable;
    assign wr      = acc && pwrite;
    assign pready  = 1'b1;
    assign mapped  = is_mapped(paddr);
    assign pslverr = acc && !mapped;

    // Update event sources
    assign upd_evt = evt.overflow || sw_update_generate || evt.restart; // [R11]
    // Compare matches ignored in center-aligned counting
    assign match_evt = center_mode ? '0 : evt.match[NCH-1:0]; // [R13]

    // Hardware set vector for the flag register
    always_comb
    begin
        flag_set = '0;
        flag_set[`TCORE_BIT_TRIG_IRQ] = evt.trig; // [R12]
        flag_set[`TCORE_BIT_UPD_IRQ]  = upd_evt;  // [R11]
        flag_set[NCH-1:0]             = match_evt; // [R13]
    end

    // Flags: write zero clears, hardware set wins
    always_comb
    begin
        next_flags = event_flags;
        if (wr && paddr == `TCORE_OFS_FLAGS)
        begin
            next_flags = event_flags & pwdata; // [R12]
        end
        next_flags = (next_flags | flag_set) & `TCORE_FLAG_MASK; // [R12]
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            event_flags <= `TCORE_RST_VALUE;
        else
            event_flags <= next_flags;
    end

    // Configuration registers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            channel_output_enable    <= `TCORE_RST_VALUE;
            output_polarity_config   <= `TCORE_RST_VALUE; // [R8]
            dma_and_interrupt_enable <= `TCORE_RST_VALUE; // [R1]
        end
        else if (wr)
        begin
            case (paddr)
                `TCORE_OFS_OUT_EN:
                    channel_output_enable <= pwdata & `TCORE_CH_MASK;
                `TCORE_OFS_POLARITY:
                    output_polarity_config <= pwdata & `TCORE_CH_MASK; // [R8]
                `TCORE_OFS_REQ_EN:
                    dma_and_interrupt_enable <= pwdata &
                                                `TCORE_REQ_EN_MASK; // [R1]
                default:
                    ;
            endcase
        end
    end

    // Registered read data
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `TCORE_OFS_OUT_EN:   prdata <= channel_output_enable;
                `TCORE_OFS_POLARITY: prdata <= output_polarity_config;
                `TCORE_OFS_REQ_EN:   prdata <= dma_and_interrupt_enable;
                `TCORE_OFS_FLAGS:    prdata <= event_flags;
                default:             prdata <= '0;
            endcase
        end
    end

    // Per-channel output: polarity then gate
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_chan
            assign next_pin_out[g] = channel_output_enable[2*g] ? // [R9]
                (chan_ref[g] ^ output_polarity_config[2*g]) : 1'b0; // [R8]
        end
    endgenerate

    // Pin levels registered in one process, one driver for the vector
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            chan_pin_out <= '0;
        else
            chan_pin_out <= next_pin_out; // [R9]
    end

    // Interrupt levels from flags and enables
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            irq_req <= '0;
        else
        begin
            irq_req.trig <= next_flags[`TCORE_BIT_TRIG_IRQ] &&
                dma_and_interrupt_enable[`TCORE_BIT_TRIG_IRQ]; // [R5] [R10]
            irq_req.upd <= next_flags[`TCORE_BIT_UPD_IRQ] &&
                dma_and_interrupt_enable[`TCORE_BIT_UPD_IRQ]; // [R6] [R10]
            irq_req.chan <= next_flags[3:0] &
                dma_and_interrupt_enable[3:0]; // [R7] [R10]
        end
    end

    // DMA request pulses, one cycle after the event
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            dma_req <= '0;
        else
        begin
            dma_req.trig <= evt.trig &&
                dma_and_interrupt_enable[`TCORE_BIT_TRIG_DMA]; // [R2]
            dma_req.upd <= upd_evt &&
                dma_and_interrupt_enable[`TCORE_BIT_UPD_DMA]; // [R3]
            dma_req.chan <= match_evt &
                dma_and_interrupt_enable[19:16]; // [R4]
        end
    end

    // Checks on requests, flags, registers and pins
    sequence s_trig_evt;
        evt.trig && dma_and_interrupt_enable[`TCORE_BIT_TRIG_DMA];
    endsequence
    property p_trig_dma;
        @(posedge clock) disable iff (sys_rst) s_trig_evt |=> dma_req.trig;
    endproperty
    a_trig_dma: assert property (p_trig_dma) // [R2]
        else $error("trig dma missing");
    property p_upd_dma;
        @(posedge clock) disable iff (sys_rst)
        !dma_and_interrupt_enable[`TCORE_BIT_UPD_DMA] |=> !dma_req.upd;
    endproperty
    a_upd_dma: assert property (p_upd_dma) // [R3]
        else $error("upd dma leak");
    property p_ch_dma;
        @(posedge clock) disable iff (sys_rst)
        dma_req.chan[0] |-> $past(dma_and_interrupt_enable[16]);
    endproperty
    a_ch_dma: assert property (p_ch_dma) // [R4]
        else $error("ch dma leak");
    // Interrupt levels use the enable value of the previous cycle
    property p_trig_irq;
        @(posedge clock) disable iff (sys_rst)
        irq_req.trig |-> $past(dma_and_interrupt_enable[10]) &&
                         event_flags[`TCORE_BIT_TRIG_IRQ];
    endproperty
    a_trig_irq: assert property (p_trig_irq) // [R5]
        else $error("trig irq bad");
    property p_upd_flag;
        @(posedge clock) disable iff (sys_rst)
        evt.overflow |=> event_flags[`TCORE_BIT_UPD_IRQ];
    endproperty
    a_upd_flag: assert property (p_upd_flag) // [R11]
        else $error("upd flag");
    property p_upd_irq;
        @(posedge clock) disable iff (sys_rst)
        event_flags[8] && $past(dma_and_interrupt_enable[8]) |-> irq_req.upd;
    endproperty
    a_upd_irq: assert property (p_upd_irq) // [R6]
        else $error("upd irq");
    property p_ch_irq;
        @(posedge clock) disable iff (sys_rst)
        irq_req.chan[3] |-> $past(dma_and_interrupt_enable[3]);
    endproperty
    a_ch_irq: assert property (p_ch_irq) // [R7]
        else $error("ch irq leak");
    property p_gate;
        @(posedge clock) disable iff (sys_rst)
        !channel_output_enable[0] |=> !chan_pin_out[0];
    endproperty
    a_gate: assert property (p_gate) // [R9]
        else $error("pin not gated");
    property p_pol;
        @(posedge clock) disable iff (sys_rst)
        channel_output_enable[0] |=> chan_pin_out[0] ==
            ($past(chan_ref[0]) ^ $past(output_polarity_config[0]));
    endproperty
    a_pol: assert property (p_pol) // [R8]
        else $error("polarity wrong");
    property p_trig_hold;
        @(posedge clock) disable iff (sys_rst)
        event_flags[10] && !(wr && paddr == `TCORE_OFS_FLAGS)
        |=> event_flags[10];
    endproperty
    a_trig_hold: assert property (p_trig_hold) // [R12]
        else $error("flag lost");
    property p_center;
        @(posedge clock) disable iff (sys_rst)
        center_mode |=> !dma_req.chan[0];
    endproperty
    a_center: assert property (p_center) // [R13]
        else $error("center match");
    property p_rst;
        @(posedge clock) sys_rst |=> dma_and_interrupt_enable == 32'h0;
    endproperty
    a_rst: assert property (p_rst) // [R1]
        else $error("reset value");
    // Write of zero clears the trigger flag when no event collides
    sequence s_trig_clr;
        event_flags[10] && wr && paddr == `TCORE_OFS_FLAGS &&
        !pwdata[10] && !evt.trig;
    endsequence
    property p_trig_clr;
        @(posedge clock) disable iff (sys_rst)
        s_trig_clr |=> !event_flags[10];
    endproperty
    a_trig_clr: assert property (p_trig_clr) // [R12]
        else $error("flag not cleared");
    property p_trig_set;
        @(posedge clock) disable iff (sys_rst)
        evt.trig |=> event_flags[`TCORE_BIT_TRIG_IRQ];
    endproperty
    a_trig_set: assert property (p_trig_set) // [R12]
        else $error("trig flag not set");
    property p_match_set;
        @(posedge clock) disable iff (sys_rst)
        !center_mode && evt.match[0] |=> event_flags[0];
    endproperty
    a_match_set: assert property (p_match_set) // [R13]
        else $error("match flag not set");
    property p_center_flag;
        @(posedge clock) disable iff (sys_rst)
        center_mode && !event_flags[1] |=> !event_flags[1];
    endproperty
    a_center_flag: assert property (p_center_flag) // [R13]
        else $error("match flag in center mode");
    property p_irq_off;
        @(posedge clock) disable iff (sys_rst)
        !event_flags[`TCORE_BIT_TRIG_IRQ] |-> !irq_req.trig;
    endproperty
    a_irq_off: assert property (p_irq_off) // [R10]
        else $error("irq without flag");
    property p_sw_upd;
        @(posedge clock) disable iff (sys_rst)
        sw_update_generate && dma_and_interrupt_enable[`TCORE_BIT_UPD_DMA]
        |=> dma_req.upd;
    endproperty
    a_sw_upd: assert property (p_sw_upd) // [R11]
        else $error("software update lost");
    property p_wr_en;
        @(posedge clock) disable iff (sys_rst)
        wr && paddr == `TCORE_OFS_REQ_EN |=> dma_and_interrupt_enable ==
            ($past(pwdata) & `TCORE_REQ_EN_MASK);
    endproperty
    a_wr_en: assert property (p_wr_en) // [R1]
        else $error("enable write lost");
    property p_pol_wr;
        @(posedge clock) disable iff (sys_rst)
        wr && paddr == `TCORE_OFS_POLARITY |=> output_polarity_config ==
            ($past(pwdata) & `TCORE_CH_MASK);
    endproperty
    a_pol_wr: assert property (p_pol_wr) // [R8]
        else $error("polarity write lost");
endmodule : tcore_out_req
`default_nettype wire

// ---- rtl/tcore_defs.svh ----
// Register offsets, field positions and reset values of the output slice
`ifndef TCORE_DEFS_SVH
`define TCORE_DEFS_SVH
`define TCORE_OFS_OUT_EN    12'h050
`define TCORE_OFS_POLARITY  12'h054
`define TCORE_OFS_REQ_EN    12'h074
`define TCORE_OFS_FLAGS     12'h07C
`define TCORE_BIT_TRIG_DMA  26
`define TCORE_BIT_UPD_DMA   24
`define TCORE_BIT_CH_DMA    16
`define TCORE_BIT_TRIG_IRQ  10
`define TCORE_BIT_UPD_IRQ   8
`define TCORE_BIT_CH_IRQ    0
`define TCORE_REQ_EN_MASK   32'h050F050F
`define TCORE_CH_MASK       32'h00000055
`define TCORE_FLAG_MASK     32'h0000050F
`define TCORE_RST_VALUE     32'h00000000
`endif

// ---- rtl/tcore_pkg.sv ----
// Types shared by the output and request slice
package tcore_pkg;
    // Hardware event strobes from the timer core
    typedef struct packed {
        logic       trig;      // Trigger event
        logic       overflow;  // Counter over or underflow
        logic       restart;   // Slave trigger restart
        logic [3:0] match;     // Counter equals compare value
    } tcore_evt_t;
    // Requests toward interrupt and DMA controllers
    typedef struct packed {
        logic       trig;
        logic       upd;
        logic [3:0] chan;
    } tcore_req_t;
endpackage : tcore_pkg

// ---- test/tcore_far_model.sv ----
// Behavioural DMA controller on the block's request side
`timescale 1ns/1ps
`default_nettype none
module tcore_far_model (
    input  wire logic                 clock,     // Peripheral clock
    input  wire logic                 sys_rst,   // Synchronous reset
    input  wire tcore_pkg::tcore_req_t dma_req,  // One-cycle DMA requests
    output logic [15:0]               dma_taken  // DMA requests served
);
    import tcore_pkg::*;
    // Serve every request pulse at once, one transfer per set bit
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            dma_taken <= '0;
        else
            dma_taken <= dma_taken + 16'($countones(dma_req));
    end
endmodule : tcore_far_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the timer output and request slice
`timescale 1ns/1ps
`default_nettype none
`include "tcore_defs.svh"
module tb_top;
    import tcore_pkg::*;
    logic        clock = 1'b0, sys_rst = 1'b1, err;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q, r, p, en, flg, ev;
    logic        pready, pslverr, center_mode = 1'b0;
    logic        sw_update_generate = 1'b0;
    logic [3:0]  chan_ref = '0, chan_pin_out;
    tcore_evt_t  evt = '0;
    tcore_req_t  irq_req, dma_req;
    logic [15:0] dma_taken, dma_exp = '0;
    logic [31:0] seed = 32'h00010D37;
    logic [11:0] ofs [5] = '{12'h050, 12'h054, 12'h074, 12'h07C, 12'h100};
    int          fails = 0, cmp_count = 0, cyc = 0;
    tcore_out_req i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_ref(chan_ref), .evt(evt), .center_mode(center_mode),
        .sw_update_generate(sw_update_generate),
        .chan_pin_out(chan_pin_out), .irq_req(irq_req), .dma_req(dma_req));
    tcore_far_model i_far (.clock(clock), .sys_rst(sys_rst),
        .dma_req(dma_req), .dma_taken(dma_taken));
    initial forever #25 clock = ~clock;
    // Xorshift source, repeatable from its fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Flag-layout word onto the request struct
    function automatic tcore_req_t req_of(logic [31:0] x);
        return {x[10], x[8], x[3:0]};
    endfunction : req_of
    // Per-channel bits held at even positions
    function automatic logic [3:0] evn(logic [31:0] x);
        return {x[6], x[4], x[2], x[0]};
    endfunction : evn
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // One APB transfer, held until pready is seen high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One-cycle event strobe, then requests checked in the next cycle
    task automatic fire(tcore_evt_t e, logic sw, logic cm);
        @(posedge clock);
        evt <= e;
        sw_update_generate <= sw;
        center_mode <= cm;
        ev = {21'h0, e.trig, 1'b0, e.overflow | e.restart | sw, 4'h0,
              cm ? 4'h0 : e.match};
        flg = flg | ev;
        dma_exp = dma_exp + 16'($countones(req_of(ev & (en >> 16))));
        @(posedge clock);
        evt <= '0;
        sw_update_generate <= 1'b0;
        #1;
        chk(32'(dma_req), 32'(req_of(ev & (en >> 16))));
        chk(32'(irq_req), 32'(req_of(flg & en)));
    endtask : fire
    // Cut a hang short
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            test_done();
        end
    end
    initial
    begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        en = '0;
        flg = '0;
        // Reset values, then an unmapped place
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, ofs[i], '0);
            chk(q, '0);
        end
        chk(32'(err), 32'h1);
        // Enables, paired events with an idle cycle between, flag clearing
        for (int k = 0; k < 40; k++)
        begin
            r = rnd();
            en = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h0 : rnd();
            apb(1'b1, `TCORE_OFS_REQ_EN, en);
            en = en & `TCORE_REQ_EN_MASK;
            apb(1'b0, `TCORE_OFS_REQ_EN, '0);
            chk(q, en);
            fire(tcore_evt_t'((k == 0) ? 7'h7F : r[6:0]), r[7], r[8] & r[9]);
            fire(tcore_evt_t'(r[16:10]), r[17], 1'b0);
            apb(1'b0, `TCORE_OFS_FLAGS, '0);
            chk(q, flg);
            apb(1'b1, `TCORE_OFS_FLAGS, r);
            flg = flg & r;
            repeat (2) @(posedge clock);
            #1 chk(32'(irq_req), 32'(req_of(flg & en)));
        end
        // Output enable and polarity per channel
        for (int k = 0; k < 12; k++)
        begin
            r = (k == 0) ? 32'hFFFFFFFF : rnd();
            p = {r[15:0], r[31:16]};
            apb(1'b1, `TCORE_OFS_OUT_EN, r);
            apb(1'b1, `TCORE_OFS_POLARITY, p);
            chan_ref <= r[11:8];
            apb(1'b0, `TCORE_OFS_POLARITY, '0);
            chk(q, p & `TCORE_CH_MASK);
            apb(1'b0, `TCORE_OFS_OUT_EN, '0);
            chk(q, r & `TCORE_CH_MASK);
            repeat (2) @(posedge clock);
            #1;
            chk(32'(chan_pin_out), 32'((r[11:8] ^ evn(p)) & evn(r)));
        end
        chk(32'(dma_taken), 32'(dma_exp));
        test_done();
    end
endmodule : tb_top
`default_nettype wire
